// ==== design/ampbs_port.sv ====
`timescale 1ns/100ps
module ampbs_port import ampbs_pkg::*; #(
   parameter int STROBE_CNT = STROBE_CYC
) (
   input wire logic clk,
   input wire logic srst,
   // user request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_cond,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic rsp_rvalid,
   output logic rsp_done,
   // pin mux configuration
   input wire logic [FLAG_N-1:0] cfg_addr_flag_en,
   input wire logic [PWM_N-1:0] cfg_addr_pwm_en,
   input wire logic [FLAG_N-1:0] cfg_data_flag_en,
   // flag and pwm sources and sinks
   input wire logic [FLAG_N-1:0] addr_muxed_flags_out,
   input wire logic [FLAG_N-1:0] addr_muxed_flags_dir,
   output logic [FLAG_N-1:0] addr_muxed_flags_in,
   input wire logic [PWM_N-1:0] pwm_out,
   input wire logic [FLAG_N-1:0] data_muxed_flags_out,
   input wire logic [FLAG_N-1:0] data_muxed_flags_dir,
   output logic [FLAG_N-1:0] data_muxed_flags_in,
   input wire logic [LOW_FLAG_N-1:0] low_gp_flags_out,
   input wire logic [LOW_FLAG_N-1:0] low_gp_flags_dir,
   output logic [LOW_FLAG_N-1:0] low_gp_flags_in,
   // boot
   input wire logic [2:0] boot_select_pins,
   input wire logic pkg_three_pin,
   input wire logic boot_busy,
   output ampbs_boot_e boot_mode,
   output logic boot_mode_valid,
   // external pins
   input wire logic [ADDR_W-1:0] ext_addr_bus_i,
   output logic [ADDR_W-1:0] ext_addr_bus_o,
   output logic [ADDR_W-1:0] ext_addr_bus_oe,
   input wire logic [DATA_W-1:0] ext_data_bus_i,
   output logic [DATA_W-1:0] ext_data_bus_o,
   output logic [DATA_W-1:0] ext_data_bus_oe,
   input wire logic [LOW_FLAG_N-1:0] low_gp_flags_i,
   output logic [LOW_FLAG_N-1:0] low_gp_flags_o,
   output logic [LOW_FLAG_N-1:0] low_gp_flags_oe,
   input wire logic mem_ack_in,
   output logic [BANK_N-1:0] bank_select_n_o,
   output logic bank_select_n_oe,
   output logic mem_read_strobe_n_o,
   output logic mem_read_strobe_n_oe,
   output logic mem_write_strobe_n_o,
   output logic mem_write_strobe_n_oe
);
   ampbs_boot_if bif ();

   // boot strap decoder
   ampbs_boot_dec u_boot (
      .clk (clk),
      .srst (srst),
      .boot_select_pins (boot_select_pins),
      .pkg_three_pin (pkg_three_pin),
      .bif (bif)
   );

   // sequencer state
   ampbs_state_e st_q, st_d; // access phase
   logic [CNT_W-1:0] cnt_q, cnt_d; // phase cycle counter
   logic [ADDR_W-1:0] addr_q, addr_d; // latched access address
   logic [DATA_W-1:0] wdata_q, wdata_d; // latched write data
   logic wr_q, wr_d; // access is a write
   logic bank_q, bank_d; // decoded bank
   logic [DATA_W-1:0] rdata_q, rdata_d; // captured read word
   logic rvalid_q, rvalid_d; // read word pulse
   logic done_q, done_d; // access end pulse
   logic drive_q, drive_d; // address pins driven

   // mux configuration registers
   logic [FLAG_N-1:0] afl_q, afl_d; // address flag mode bits
   logic [PWM_N-1:0] apw_q, apw_d; // address pwm mode bits
   logic [FLAG_N-1:0] dfl_q, dfl_d; // data flag mode bits

   // pin registers
   logic [ADDR_W-1:0] apin_q, apin_d; // address pin value
   logic [ADDR_W-1:0] aoe_q, aoe_d; // address pin enable
   logic [DATA_W-1:0] dpin_q, dpin_d; // data pin value
   logic [DATA_W-1:0] doe_q, doe_d; // data pin enable
   logic [BANK_N-1:0] bsel_q, bsel_d; // bank selects, active low
   logic rd_q, rd_d; // read strobe, active low
   logic wrs_q, wrs_d; // write strobe, active low
   logic ctl_oe_q, ctl_oe_d; // control pin enable
   logic [LOW_FLAG_N-1:0] lfo_q, lfo_d; // low flag value
   logic [LOW_FLAG_N-1:0] lfe_q, lfe_d; // low flag enable
   logic [FLAG_N-1:0] afi_q, afi_d; // address flag inputs
   logic [FLAG_N-1:0] dfi_q, dfi_d; // data flag inputs
   logic [LOW_FLAG_N-1:0] lfi_q, lfi_d; // low flag inputs

   logic booting; // a boot mode needing the port was latched
   logic busy; // external access in progress

   assign booting = bif.boot_valid && (bif.boot_mode != BOOT_NONE) && (bif.boot_mode != BOOT_RESERVED);
   assign busy = (st_q != ST_IDLE);
   assign req_ready = (st_q == ST_IDLE);

   // access sequencer next state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_d = wr_q;
      bank_d = bank_q;
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      done_d = 1'b0;
      drive_d = drive_q || booting;
      unique case (st_q)
         ST_IDLE: begin
            if (req_valid) begin
               if (!req_cond) begin
                  done_d = 1'b1; // false condition: no select
               end else begin
                  // while boot_busy is high in flash boot mode, accesses land on the second bank
                  addr_d = req_addr;
                  bank_d = req_addr[BANK_BIT] || (boot_busy && bif.boot_mode == BOOT_FLASH);
                  wdata_d = req_wdata;
                  wr_d = req_write;
                  drive_d = 1'b1;
                  cnt_d = CNT_W'(SETUP_CYC - 1);
                  st_d = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            if (cnt_q == '0) begin
               cnt_d = CNT_W'(STROBE_CNT - 1);
               st_d = ST_STROBE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_STROBE: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (mem_ack_in) begin
               // acknowledge high lets the access finish
               if (!wr_q) begin
                  rdata_d = ext_data_bus_i;
                  rvalid_d = 1'b1;
               end
               cnt_d = CNT_W'(HOLD_CYC - 1);
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (cnt_q == '0) begin
               done_d = 1'b1;
               st_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
      endcase
   end

   // configuration follows the ports, memory mode from reset
   always_comb begin
      afl_d = cfg_addr_flag_en;
      apw_d = cfg_addr_pwm_en;
      dfl_d = cfg_data_flag_en;
   end

   // per-pin mux of the address bus
   genvar gi;
   generate
      for (gi = 0; gi < ADDR_W; gi++) begin : g_apin
         if (gi >= ADDR_FLAG_BASE && gi < ADDR_FLAG_BASE + FLAG_N) begin : g_flag
            always_comb begin
               if (afl_q[gi - ADDR_FLAG_BASE]) begin
                  apin_d[gi] = addr_muxed_flags_out[gi - ADDR_FLAG_BASE];
                  aoe_d[gi] = addr_muxed_flags_dir[gi - ADDR_FLAG_BASE];
               end else begin
                  apin_d[gi] = addr_q[gi];
                  aoe_d[gi] = drive_q;
               end
            end
         end else if (gi >= ADDR_PWM_BASE && gi < ADDR_PWM_BASE + PWM_N) begin : g_pwm
            always_comb begin
               if (apw_q[gi - ADDR_PWM_BASE]) begin
                  apin_d[gi] = pwm_out[gi - ADDR_PWM_BASE];
                  aoe_d[gi] = 1'b1;
               end else begin
                  apin_d[gi] = addr_q[gi];
                  aoe_d[gi] = drive_q;
               end
            end
         end else begin : g_mem
            always_comb begin
               apin_d[gi] = addr_q[gi];
               aoe_d[gi] = drive_q;
            end
         end
      end
      // per-pin mux of the data bus
      for (gi = 0; gi < DATA_W; gi++) begin : g_dpin
         if (gi >= DATA_FLAG_BASE && gi < DATA_FLAG_BASE + FLAG_N) begin : g_flag
            always_comb begin
               if (dfl_q[gi - DATA_FLAG_BASE]) begin
                  dpin_d[gi] = data_muxed_flags_out[gi - DATA_FLAG_BASE];
                  doe_d[gi] = data_muxed_flags_dir[gi - DATA_FLAG_BASE];
               end else begin
                  dpin_d[gi] = wdata_q[gi];
                  doe_d[gi] = busy && wr_q;
               end
            end
         end else begin : g_mem
            always_comb begin
               dpin_d[gi] = wdata_q[gi];
               doe_d[gi] = busy && wr_q; // data driven only for writes
            end
         end
      end
   endgenerate

   // control pins and flag inputs
   always_comb begin
      for (int b = 0; b < BANK_N; b++) begin
         bsel_d[b] = !(busy && (bank_q == b[0]));
      end
      rd_d = !((st_d == ST_STROBE || st_q == ST_STROBE) && !wr_q && busy);
      wrs_d = !((st_d == ST_STROBE || st_q == ST_STROBE) && wr_q && busy);
      if (st_d != ST_STROBE) begin
         rd_d = 1'b1;
         wrs_d = 1'b1;
      end
      ctl_oe_d = 1'b1; // driven once out of reset
      lfo_d = low_gp_flags_out;
      lfe_d = low_gp_flags_dir;
      afi_d = ext_addr_bus_i[ADDR_FLAG_BASE +: FLAG_N];
      dfi_d = ext_data_bus_i[DATA_FLAG_BASE +: FLAG_N];
      lfi_d = low_gp_flags_i;
   end

   // registers only; reset floats every pin
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
         wr_q <= 1'b0;
         bank_q <= 1'b0;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         done_q <= 1'b0;
         drive_q <= 1'b0;
         afl_q <= '0; // memory mode
         apw_q <= '0;
         dfl_q <= '0;
         apin_q <= '0;
         aoe_q <= '0;
         dpin_q <= '0;
         doe_q <= '0;
         bsel_q <= '1;
         rd_q <= 1'b1;
         wrs_q <= 1'b1;
         ctl_oe_q <= 1'b0;
         lfo_q <= '0;
         lfe_q <= '0; // low flags start as inputs
         afi_q <= '0;
         dfi_q <= '0;
         lfi_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         bank_q <= bank_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         done_q <= done_d;
         drive_q <= drive_d;
         afl_q <= afl_d;
         apw_q <= apw_d;
         dfl_q <= dfl_d;
         apin_q <= apin_d;
         aoe_q <= aoe_d;
         dpin_q <= dpin_d;
         doe_q <= doe_d;
         bsel_q <= bsel_d;
         rd_q <= rd_d;
         wrs_q <= wrs_d;
         ctl_oe_q <= ctl_oe_d;
         lfo_q <= lfo_d;
         lfe_q <= lfe_d;
         afi_q <= afi_d;
         dfi_q <= dfi_d;
         lfi_q <= lfi_d;
      end
   end

   // outputs
   assign rsp_rdata = rdata_q;
   assign rsp_rvalid = rvalid_q;
   assign rsp_done = done_q;
   assign boot_mode = bif.boot_mode;
   assign boot_mode_valid = bif.boot_valid;
   assign ext_addr_bus_o = apin_q;
   assign ext_addr_bus_oe = aoe_q;
   assign ext_data_bus_o = dpin_q;
   assign ext_data_bus_oe = doe_q;
   assign bank_select_n_o = bsel_q;
   assign bank_select_n_oe = ctl_oe_q;
   assign mem_read_strobe_n_o = rd_q;
   assign mem_read_strobe_n_oe = ctl_oe_q;
   assign mem_write_strobe_n_o = wrs_q;
   assign mem_write_strobe_n_oe = ctl_oe_q;
   assign low_gp_flags_o = lfo_q;
   assign low_gp_flags_oe = lfe_q;
   assign addr_muxed_flags_in = afi_q;
   assign data_muxed_flags_in = dfi_q;
   assign low_gp_flags_in = lfi_q;
endmodule // ampbs_port

// ==== design/ampbs_pkg.sv ====
package ampbs_pkg;
   // pin widths of the external port
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int BANK_N = 2;
   localparam int FLAG_N = 8;
   localparam int PWM_N = 4;
   localparam int LOW_FLAG_N = 4;
   // address bit that picks the external bank
   localparam int BANK_BIT = 23;
   // address pins that can carry flags and pwm outputs
   localparam int ADDR_FLAG_BASE = 0;
   localparam int ADDR_PWM_BASE = 8;
   // data pins that can carry flags
   localparam int DATA_FLAG_BASE = 0;

   // access timing in ns and derived clock counts
   localparam int CLK_PERIOD_NS = 25;
   localparam int SETUP_T_NS = 25;
   localparam int STROBE_T_NS = 50;
   localparam int HOLD_T_NS = 25;
   localparam int SETUP_CYC = (SETUP_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;

   // boot select codes, three-pin package
   localparam logic [2:0] BOOT3_SPI_SLAVE = 3'h0;
   localparam logic [2:0] BOOT3_SPI_MASTER = 3'h1;
   localparam logic [2:0] BOOT3_FLASH = 3'h2;
   localparam logic [2:0] BOOT3_NO_BOOT = 3'h3;
   // boot select codes, two-pin package
   localparam logic [1:0] BOOT2_SPI_SLAVE = 2'h0;
   localparam logic [1:0] BOOT2_SPI_MASTER = 2'h1;
   localparam logic [1:0] BOOT2_RESERVED = 2'h2;
   localparam logic [1:0] BOOT2_NO_BOOT = 2'h3;

   // decoded boot mode
   typedef enum logic [4:0] {
      BOOT_SPI_SLAVE = 5'b00001,
      BOOT_SPI_MASTER = 5'b00010,
      BOOT_FLASH = 5'b00100,
      BOOT_NONE = 5'b01000,
      BOOT_RESERVED = 5'b10000
   } ampbs_boot_e;

   // access sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_HOLD = 4'b1000
   } ampbs_state_e;
endpackage

// ==== design/ampbs_boot_if.sv ====
`timescale 1ns/100ps
// carries the latched boot mode from the decoder to the port
interface ampbs_boot_if;
   import ampbs_pkg::*;
   ampbs_boot_e boot_mode; // decoded mode
   logic boot_valid; // mode latched since reset release
   modport dec (output boot_mode, output boot_valid);
   modport port (input boot_mode, input boot_valid);
endinterface

// ==== design/ampbs_boot_dec.sv ====
`timescale 1ns/100ps
// latches the boot strap pins once after reset and decodes them
module ampbs_boot_dec import ampbs_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] boot_select_pins,
   input wire logic pkg_three_pin,
   ampbs_boot_if.dec bif
);
   logic cap_q, cap_d; // strap already taken
   ampbs_boot_e mode_q, mode_d; // latched mode
   ampbs_boot_e dec_mode; // live decode of the pins

   // decode of both package variants
   always_comb begin
      if (pkg_three_pin) begin
         if (boot_select_pins[2]) begin
            dec_mode = BOOT_RESERVED; // 1xx
         end else begin
            unique case (boot_select_pins[1:0])
               BOOT3_SPI_SLAVE[1:0]: dec_mode = BOOT_SPI_SLAVE;
               BOOT3_SPI_MASTER[1:0]: dec_mode = BOOT_SPI_MASTER;
               BOOT3_FLASH[1:0]: dec_mode = BOOT_FLASH;
               BOOT3_NO_BOOT[1:0]: dec_mode = BOOT_NONE;
            endcase
         end
      end else begin
         unique case (boot_select_pins[1:0])
            BOOT2_SPI_SLAVE: dec_mode = BOOT_SPI_SLAVE;
            BOOT2_SPI_MASTER: dec_mode = BOOT_SPI_MASTER;
            BOOT2_RESERVED: dec_mode = BOOT_RESERVED;
            BOOT2_NO_BOOT: dec_mode = BOOT_NONE;
         endcase
      end
   end

   // take the strap at the first edge after reset release
   always_comb begin
      cap_d = 1'b1;
      mode_d = cap_q ? mode_q : dec_mode;
   end

   // registers only
   always_ff @(posedge clk) begin
      if (srst) begin
         cap_q <= 1'b0;
         mode_q <= BOOT_NONE;
      end else begin
         cap_q <= cap_d;
         mode_q <= mode_d;
      end
   end

   assign bif.boot_mode = mode_q;
   assign bif.boot_valid = cap_q;
endmodule // ampbs_boot_dec

// ==== bench/ampbs_mem_model.sv ====
`timescale 1ns/100ps
// external asynchronous memory: 16 words per bank, slowed by a set count of strobe cycles
module ampbs_mem_model (
   input wire logic clk,
   input wire logic [1:0] sel_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [23:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [7:0] wait_cyc,
   output logic [15:0] rdata,
   output logic rdrive,
   output logic ack
);
   logic [15:0] mem_q [0:31]; // word store, bank in the top index bit
   logic [7:0] cnt_q; // cycles of the current strobe
   wire logic busy = sel_n != 2'h3 && !(rd_n && wr_n); // a strobe is low on a selected bank
   wire logic [4:0] idx = {!sel_n[1], addr[3:0]}; // bank and low address bits
   // count strobe cycles and store written words
   always @(posedge clk) begin
      cnt_q <= busy ? cnt_q + 8'h1 : 8'h0;
      if (busy && !wr_n) begin
         mem_q[idx] <= wdata;
      end
   end
   // acknowledge held low for the first cycles of a strobe, pulled up otherwise
   assign ack = !(busy && cnt_q < wait_cyc);
   // read data only while the read strobe is low
   assign rdrive = busy && !rd_n;
   assign rdata = mem_q[idx];
endmodule // ampbs_mem_model

// ==== bench/ampbs_port_chk.sv ====
`timescale 1ns/100ps
// pin level checks of the port against its request side
module ampbs_port_chk import ampbs_pkg::*; #(
   parameter int STROBE_CNT = 2
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic req_cond,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic rsp_done,
   input wire logic boot_busy,
   input wire ampbs_boot_e boot_mode,
   input wire logic [ADDR_W-1:0] ext_addr_bus_o,
   input wire logic [ADDR_W-1:0] ext_addr_bus_oe,
   input wire logic [DATA_W-1:0] ext_data_bus_o,
   input wire logic [DATA_W-1:0] ext_data_bus_oe,
   input wire logic mem_ack_in,
   input wire logic [BANK_N-1:0] bank_select_n_o,
   input wire logic bank_select_n_oe,
   input wire logic mem_read_strobe_n_o,
   input wire logic mem_read_strobe_n_oe,
   input wire logic mem_write_strobe_n_o,
   input wire logic mem_write_strobe_n_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic take = req_valid && req_ready; // request accepted this cycle
   wire logic strb = !(mem_read_strobe_n_o && mem_write_strobe_n_o); // some strobe low
   AST_SEL_TAKE: assert property (
      take && req_cond && !boot_busy |=> ##1 ext_addr_bus_o == $past(req_addr, 2) && ext_addr_bus_oe == '1
      && bank_select_n_o == ($past(req_addr[BANK_BIT], 2) ? 2'h1 : 2'h2))
      else $error("address or bank select wrong after take");
   // the select pins are registered, so they follow the idle state one cycle later
   AST_IDLE_SEL: assert property ($past(req_ready) |-> bank_select_n_o == 2'h3)
      else $error("bank select active while idle");
   AST_FALSE_COND: assert property (
      take && !req_cond |-> ##[1:2] rsp_done && bank_select_n_o == 2'h3 && !strb)
      else $error("false condition still made an access");
   AST_RD_STROBE: assert property (
      take && req_cond && !req_write |=> mem_read_strobe_n_o ##1 (!mem_read_strobe_n_o && mem_write_strobe_n_o)[*2])
      else $error("read strobe sequence wrong");
   AST_WR_STROBE: assert property (
      take && req_cond && req_write |=> ##1 ext_data_bus_oe == '1 && ext_data_bus_o == $past(req_wdata, 2)
      && !mem_write_strobe_n_o && mem_read_strobe_n_o ##1 (!mem_write_strobe_n_o && mem_read_strobe_n_o))
      else $error("write data or strobe wrong");
   AST_WAIT: assert property (
      strb && !mem_ack_in |=> strb && $stable(ext_addr_bus_o) && !rsp_done)
      else $error("access ended while acknowledge low");
   AST_RESET_TRI: assert property (@(posedge clk) disable iff (1'b0) srst |=> ext_data_bus_oe == '0
      && ext_addr_bus_oe == '0 && !bank_select_n_oe && !mem_read_strobe_n_oe && !mem_write_strobe_n_oe)
      else $error("pins driven during reset");
   AST_BOOT_ADDR: assert property ($fell(srst) ##1
      boot_mode inside {BOOT_SPI_SLAVE, BOOT_SPI_MASTER, BOOT_FLASH}
      |=> ##1 ext_addr_bus_oe == '1 && ext_addr_bus_o == '0)
      else $error("address not driven low when booting");
endmodule // ampbs_port_chk

bind ampbs_port ampbs_port_chk #(.STROBE_CNT(STROBE_CNT)) u_chk (.clk, .srst, .req_valid, .req_ready,
   .req_write, .req_cond, .req_addr, .req_wdata, .rsp_done, .boot_busy, .boot_mode, .ext_addr_bus_o,
   .ext_addr_bus_oe, .ext_data_bus_o, .ext_data_bus_oe, .mem_ack_in, .bank_select_n_o, .bank_select_n_oe,
   .mem_read_strobe_n_o, .mem_read_strobe_n_oe, .mem_write_strobe_n_o, .mem_write_strobe_n_oe);

// ==== bench/tb_ampbs_port.sv ====
`timescale 1ns/100ps
// drives the port through requests, boot straps and flag pins
module tb_ampbs_port;
   import ampbs_pkg::*;
   logic clk, srst, req_valid, req_write, req_cond, pkg_three_pin, boot_busy;
   logic [ADDR_W-1:0] req_addr, addr_pin; // addr_pin: board level on undriven pins
   logic [DATA_W-1:0] req_wdata, data_pin, rd_v;
   logic [FLAG_N-1:0] cfg_addr_flag_en, cfg_data_flag_en, addr_muxed_flags_out, addr_muxed_flags_dir;
   logic [FLAG_N-1:0] data_muxed_flags_out, data_muxed_flags_dir;
   logic [PWM_N-1:0] cfg_addr_pwm_en, pwm_out;
   logic [LOW_FLAG_N-1:0] low_gp_flags_out, low_gp_flags_dir, lf_pin;
   logic [2:0] boot_select_pins;
   logic [7:0] wait_cyc; // acknowledge delay of the memory
   logic [1:0] sel_v; // bank selects seen low during an access
   logic rv_v; // read word pulse seen during an access
   int err_count, cmp_count;
   wire logic req_ready, rsp_rvalid, rsp_done, boot_mode_valid, mem_ack_in, mem_drive;
   wire logic bank_select_n_oe, mem_read_strobe_n_o, mem_read_strobe_n_oe;
   wire logic mem_write_strobe_n_o, mem_write_strobe_n_oe;
   wire logic [DATA_W-1:0] rsp_rdata, ext_data_bus_i, ext_data_bus_o, ext_data_bus_oe, mem_rdata;
   wire logic [FLAG_N-1:0] addr_muxed_flags_in, data_muxed_flags_in;
   wire logic [LOW_FLAG_N-1:0] low_gp_flags_in, low_gp_flags_i, low_gp_flags_o, low_gp_flags_oe;
   wire logic [ADDR_W-1:0] ext_addr_bus_i, ext_addr_bus_o, ext_addr_bus_oe;
   wire logic [BANK_N-1:0] bank_select_n_o;
   ampbs_boot_e boot_mode;
   ampbs_boot_e m;
   // wire levels: driver wins, else memory, else pull-up or board level
   assign ext_addr_bus_i = (ext_addr_bus_oe & ext_addr_bus_o) | (~ext_addr_bus_oe & addr_pin);
   assign ext_data_bus_i = (ext_data_bus_oe & ext_data_bus_o) | (~ext_data_bus_oe & (mem_drive ? mem_rdata : data_pin));
   assign low_gp_flags_i = (low_gp_flags_oe & low_gp_flags_o) | (~low_gp_flags_oe & lf_pin);
   ampbs_port #(.STROBE_CNT(2)) dut (.clk, .srst, .req_valid, .req_ready, .req_write, .req_cond, .req_addr,
      .req_wdata, .rsp_rdata, .rsp_rvalid, .rsp_done, .cfg_addr_flag_en, .cfg_addr_pwm_en, .cfg_data_flag_en,
      .addr_muxed_flags_out, .addr_muxed_flags_dir, .addr_muxed_flags_in, .pwm_out, .data_muxed_flags_out,
      .data_muxed_flags_dir, .data_muxed_flags_in, .low_gp_flags_out, .low_gp_flags_dir, .low_gp_flags_in,
      .boot_select_pins, .pkg_three_pin, .boot_busy, .boot_mode, .boot_mode_valid, .ext_addr_bus_i,
      .ext_addr_bus_o, .ext_addr_bus_oe, .ext_data_bus_i, .ext_data_bus_o, .ext_data_bus_oe, .low_gp_flags_i,
      .low_gp_flags_o, .low_gp_flags_oe, .mem_ack_in, .bank_select_n_o, .bank_select_n_oe, .mem_read_strobe_n_o,
      .mem_read_strobe_n_oe, .mem_write_strobe_n_o, .mem_write_strobe_n_oe);
   ampbs_mem_model u_mem (.clk, .sel_n(bank_select_n_oe ? bank_select_n_o : 2'h3),
      .rd_n(!mem_read_strobe_n_oe || mem_read_strobe_n_o), .wr_n(!mem_write_strobe_n_oe || mem_write_strobe_n_o),
      .addr(ext_addr_bus_i), .wdata(ext_data_bus_i), .wait_cyc, .rdata(mem_rdata), .rdrive(mem_drive),
      .ack(mem_ack_in));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // compares one value and counts it
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // prints the verdict and ends the run
   task tally_and_finish;
      if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // five cycles of reset, then three edges for strap latch, drive decision and pin defaults
   task do_reset;
      srst = 1'b1;
      repeat (5) @(posedge clk);
      #2 srst = 1'b0;
      repeat (3) @(posedge clk);
      #2;
   endtask
   // one access; returns one cycle after the cycle in which it is reported done
   task automatic access(input logic wr, input logic cnd, input logic [23:0] a, input logic [15:0] d, input int w);
      int n;
      n = 0;
      wait_cyc = 8'(w);
      {req_write, req_cond, req_addr, req_wdata, req_valid} = {wr, cnd, a, d, 1'b1};
      while (req_ready !== 1'b1 && n < 50) begin
         @(posedge clk);
         #2 n++;
      end
      @(posedge clk);
      #2 req_valid = 1'b0;
      {sel_v, rv_v} = {bank_select_n_o, rsp_rvalid};
      while (rsp_done !== 1'b1 && n < 100) begin
         @(posedge clk);
         #2 n++;
         sel_v = sel_v & bank_select_n_o; // selects are registered, seen from the edge after the take
         rv_v = rv_v | rsp_rvalid;
      end
      if (n >= 100) err_count++;
      rd_v = rsp_rdata;
      // let an edge pass so the next call never re-raises req_valid in this time step
      @(posedge clk);
      #2;
   endtask
   // expected mode for a strap value
   function automatic ampbs_boot_e exp_mode(input logic [2:0] p, input logic three);
      if (three) begin
         case (p)
            3'h0: return BOOT_SPI_SLAVE;
            3'h1: return BOOT_SPI_MASTER;
            3'h2: return BOOT_FLASH;
            3'h3: return BOOT_NONE;
            default: return BOOT_RESERVED;
         endcase
      end
      case (p[1:0])
         2'h0: return BOOT_SPI_SLAVE;
         2'h1: return BOOT_SPI_MASTER;
         2'h2: return BOOT_RESERVED;
         default: return BOOT_NONE;
      endcase
   endfunction
   // watchdog, far beyond the expected run of a few hundred cycles
   initial begin
      #200000;
      err_count++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      {req_valid, req_write, req_cond, boot_busy, req_addr, req_wdata} = '0;
      {cfg_addr_flag_en, cfg_data_flag_en, cfg_addr_pwm_en, pwm_out} = '0;
      {addr_muxed_flags_out, addr_muxed_flags_dir, data_muxed_flags_out, data_muxed_flags_dir} = '0;
      {low_gp_flags_out, low_gp_flags_dir, wait_cyc} = '0;
      {addr_pin, data_pin, lf_pin} = {24'hffffff, 16'hffff, 4'ha};
      {err_count, cmp_count} = '0;
      // every strap code on both packages
      for (int i = 0; i < 12; i++) begin
         boot_select_pins = (i < 8) ? 3'(i) : 3'(i - 8);
         pkg_three_pin = (i < 8);
         do_reset();
         m = exp_mode(boot_select_pins, pkg_three_pin);
         check(32'(boot_mode), 32'(m));
         check(32'(boot_mode_valid), 32'h1);
         check(32'(ext_addr_bus_oe), (m inside {BOOT_SPI_SLAVE, BOOT_SPI_MASTER, BOOT_FLASH}) ? 32'hffffff : 32'h0);
         check(32'(ext_addr_bus_o & ext_addr_bus_oe), 32'h0);
      end
      boot_select_pins = 3'h3;
      do_reset();
      check(32'(low_gp_flags_oe), 32'h0);
      check(32'(low_gp_flags_in), 32'ha);
      // writes back to back over both banks with growing waits, then read back
      for (int k = 0; k < 4; k++) begin
         access(1'b1, 1'b1, {k[0], 19'h0, 4'(k)}, 16'h1000 + 16'(k), 2 * k);
         check(32'(sel_v), k[0] ? 32'h1 : 32'h2);
         check(32'(rv_v), 32'h0);
      end
      for (int k = 0; k < 4; k++) begin
         access(1'b0, 1'b1, {k[0], 19'h0, 4'(k)}, 16'h0, 6 - 2 * k);
         check(32'(rd_v), 32'h1000 + 32'(k));
         check(32'(rv_v), 32'h1);
      end
      // a false condition leaves selects idle and memory untouched
      access(1'b1, 1'b0, 24'h0, 16'hdead, 0);
      check(32'(sel_v), 32'h3);
      access(1'b0, 1'b1, 24'h0, 16'h0, 0);
      check(32'(rd_v), 32'h1000);
      // address, pwm, data and low flag pins in their other modes
      {cfg_addr_flag_en, addr_muxed_flags_dir, addr_muxed_flags_out, addr_pin} = {8'hff, 8'hf0, 8'ha5, 24'h00005a};
      {cfg_addr_pwm_en, pwm_out} = {4'hf, 4'h9};
      {cfg_data_flag_en, data_muxed_flags_dir, data_muxed_flags_out, data_pin} = {8'hff, 8'h0f, 8'h3c, 16'h00c3};
      {low_gp_flags_dir, low_gp_flags_out} = {4'h5, 4'hf};
      repeat (3) @(posedge clk);
      #2;
      check(32'(ext_addr_bus_oe[11:0]), 32'hff0);
      check(32'(ext_addr_bus_o[11:4]), 32'h9a);
      check(32'(addr_muxed_flags_in), 32'haa);
      check(32'(ext_data_bus_oe[7:0]), 32'h0f);
      check(32'(data_muxed_flags_in), 32'hcc);
      check(32'(low_gp_flags_in), 32'hf);
      {cfg_addr_flag_en, cfg_addr_pwm_en, cfg_data_flag_en, addr_pin, data_pin} = {20'h0, 24'hffffff, 16'hffff};
      // flash boot in progress takes the second bank select
      {boot_select_pins, pkg_three_pin} = {3'h2, 1'b1};
      do_reset();
      boot_busy = 1'b1;
      access(1'b0, 1'b1, 24'h000001, 16'h0, 0);
      check(32'(sel_v), 32'h1);
      check(32'(rd_v), 32'h1001);
      boot_busy = 1'b0;
      tally_and_finish();
   end
endmodule // tb_ampbs_port
